// ==== hw/pwm_defines.svh ====
// register offsets, field positions, reset values and timing constants of the pwm block
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH
`define PWM_PERIOD_REG_OFS 12'h000
`define PWM_TIMER_CTRL_OFS 12'h004
`define PWM_DUTY_UPPER_OFS 12'h008
`define PWM_CAPTURE_CTRL_OFS 12'h00C
`define PWM_DUTY_SHADOW_OFS 12'h010
`define PWM_TIMER_COUNT_OFS 12'h014
`define PWM_STATUS_OFS 12'h018
`define PWM_PERIOD_RST 8'hFF
`define PWM_TIMER_CTRL_RST 3'h0
`define PWM_DUTY_UPPER_RST 8'h00
`define PWM_CAPTURE_CTRL_RST 6'h00
`define PWM_TIMER_ON_BIT 2
`define PWM_PRESCALE_LSB 0
`define PWM_PRESCALE_MSB 1
`define PWM_MODE_LSB 0
`define PWM_MODE_MSB 3
`define PWM_DUTY_LOW_LSB 4
`define PWM_DUTY_LOW_MSB 5
`define PWM_MODE_PWM 4'hC
`define PWM_PHASE_STEPS 2'h3
`endif

// ==== hw/pwm_duty_period_generator.sv ====
// pwm output stage with period timer, prescaler, double-buffered duty and apb registers
`include "pwm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_period_generator
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_data_latch,
  output logic pwm_output_pin,
  output logic pwm_owns_pin
);

  logic [7:0] period_register;
  pwm_pkg::timer_ctrl_type timer2_control;
  logic [7:0] duty_upper_register;
  pwm_pkg::capture_ctrl_type capture_pwm_control;
  logic [7:0] duty_shadow_register;
  logic [1:0] duty_shadow_low;
  logic [7:0] timer2_count;
  logic [3:0] prescale_count;
  logic [1:0] osc_phase;
  logic pwm_level;
  logic pwm_active;
  logic inc_tick;
  logic [1:0] low_bits;
  logic [9:0] time_base;
  logic [9:0] duty_pending;
  logic [9:0] duty_active;
  logic [3:0] prescale_last;
  logic period_end;
  logic base_step;
  logic wr_access;
  logic rd_access;
  logic addr_mapped;
  logic [31:0] next_prdata;

  assign pwm_active = (capture_pwm_control.mode == `PWM_MODE_PWM);
  // software-written duty value and the buffered copy used for comparison
  assign duty_pending = {duty_upper_register, capture_pwm_control.duty_low_bits};
  assign duty_active = {duty_shadow_register, duty_shadow_low};

  // terminal count of the prescaler per ratio
  always_comb
  begin
    case (pwm_pkg::prescale_type'(timer2_control.prescale))
      pwm_pkg::prescale_1: prescale_last = 4'h0;
      pwm_pkg::prescale_4: prescale_last = 4'h3;
      default: prescale_last = 4'hF;
    endcase
  end

  // two fine bits: osc phase at 1:1, prescaler bits 1:0 at 1:4, prescaler top bits 3:2 at 1:16
  always_comb
  begin
    case (pwm_pkg::prescale_type'(timer2_control.prescale))
      pwm_pkg::prescale_1: low_bits = osc_phase;
      pwm_pkg::prescale_4: low_bits = prescale_count[1:0];
      default: low_bits = prescale_count[3:2];
    endcase
  end

  assign time_base = {timer2_count, low_bits};
  // timer advances once per four osc phases times prescale
  assign inc_tick = timer2_control.timer_on && (osc_phase == `PWM_PHASE_STEPS) &&
                    (prescale_count == prescale_last);
  assign period_end = inc_tick && (timer2_count == period_register);
  // the fine time base steps every pclk at 1:1, otherwise when the prescaler bits used as low_bits step
  assign base_step = timer2_control.timer_on && ((timer2_control.prescale == 2'h0) ||
                     ((osc_phase == `PWM_PHASE_STEPS) &&
                      ((timer2_control.prescale == 2'h1) || (prescale_count[1:0] == 2'h3))));

  // oscillator phase counter, runs only while timer_on is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_phase <= 2'h0;
    else if (timer2_control.timer_on)
      osc_phase <= osc_phase + 2'h1;
  end

  // prescaler counts whole osc quadruples
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prescale_count <= 4'h0;
    else if (timer2_control.timer_on && osc_phase == `PWM_PHASE_STEPS)
    begin
      if (prescale_count == prescale_last)
        prescale_count <= 4'h0;
      else
        prescale_count <= prescale_count + 4'h1;
    end
  end

  // period timer; cleared after matching the period register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer2_count <= 8'h00;
    else if (period_end)
      timer2_count <= 8'h00;
    else if (inc_tick)
      timer2_count <= timer2_count + 8'h01;
  end

  // shadow duty loads only at period end, never from the bus in pwm mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duty_shadow_register <= 8'h00;
      duty_shadow_low <= 2'h0;
    end
    else if (period_end)
    begin
      duty_shadow_register <= duty_upper_register;
      duty_shadow_low <= capture_pwm_control.duty_low_bits;
    end
    else if (wr_access && !pwm_active && paddr == `PWM_DUTY_SHADOW_OFS && pstrb[0])
      duty_shadow_register <= pwdata[7:0];
  end

  // waveform: set at period start unless the duty is zero, cleared on duty match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_level <= 1'b0;
    else if (!pwm_active)
      pwm_level <= 1'b0;
    else if (period_end)
      pwm_level <= (duty_pending != 10'h000);
    else if (base_step && duty_active != 10'h000 && time_base == duty_active - 10'h001)
      pwm_level <= 1'b0;
  end

  // ownership flag: pwm owns the pin only while the mode field equals PWM_MODE_PWM
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_owns_pin <= 1'b0;
    else
      pwm_owns_pin <= pwm_active;
  end

  // pin mux: waveform while pwm owns the pin, port latch otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_output_pin <= 1'b0;
    else if (pwm_active)
      pwm_output_pin <= pwm_level;
    else
      pwm_output_pin <= port_data_latch;
  end

  // apb decode
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && !penable && !pwrite;
  always_comb
  begin
    case (paddr)
      `PWM_PERIOD_REG_OFS, `PWM_TIMER_CTRL_OFS, `PWM_DUTY_UPPER_OFS, `PWM_CAPTURE_CTRL_OFS,
      `PWM_DUTY_SHADOW_OFS, `PWM_TIMER_COUNT_OFS, `PWM_STATUS_OFS: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  // period register write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      period_register <= `PWM_PERIOD_RST;
    else if (wr_access && pstrb[0] && paddr == `PWM_PERIOD_REG_OFS)
      period_register <= pwdata[7:0];
  end

  // timer control write: run bit and prescale ratio
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer2_control <= `PWM_TIMER_CTRL_RST;
    else if (wr_access && pstrb[0] && paddr == `PWM_TIMER_CTRL_OFS)
      timer2_control <= pwdata[2:0];
  end

  // duty upper bits write, allowed at any time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      duty_upper_register <= `PWM_DUTY_UPPER_RST;
    else if (wr_access && pstrb[0] && paddr == `PWM_DUTY_UPPER_OFS)
      duty_upper_register <= pwdata[7:0];
  end

  // control write: mode and duty low bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_pwm_control <= `PWM_CAPTURE_CTRL_RST;
    else if (wr_access && pstrb[0] && paddr == `PWM_CAPTURE_CTRL_OFS)
      capture_pwm_control <= pwdata[5:0];
  end

  // read mux
  always_comb
  begin
    next_prdata = 32'h00000000;
    case (paddr)
      `PWM_PERIOD_REG_OFS: next_prdata[7:0] = period_register;
      `PWM_TIMER_CTRL_OFS: next_prdata[2:0] = timer2_control;
      `PWM_DUTY_UPPER_OFS: next_prdata[7:0] = duty_upper_register;
      `PWM_CAPTURE_CTRL_OFS: next_prdata[5:0] = capture_pwm_control;
      `PWM_DUTY_SHADOW_OFS: next_prdata[9:0] = duty_active;
      `PWM_TIMER_COUNT_OFS: next_prdata[9:0] = time_base;
      `PWM_STATUS_OFS: next_prdata[1:0] = {pwm_active, pwm_level};
      default: next_prdata = 32'h00000000;
    endcase
  end

  // ready: high in the first access cycle, a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  // error: unmapped address, in the same cycle as ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && !addr_mapped;
  end

  // read data captured at the setup edge, held until the next read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_access)
      prdata <= next_prdata;
  end

endmodule // pwm_duty_period_generator
`default_nettype wire

// ==== hw/pwm_pkg.sv ====
// types shared by the pwm block
package pwm_pkg;
  typedef enum logic [1:0] {prescale_1, prescale_4, prescale_16, prescale_16b} prescale_type;
  typedef struct packed {
    logic       timer_on;
    logic [1:0] prescale;
  } timer_ctrl_type;
  typedef struct packed {
    logic [1:0] duty_low_bits;
    logic [3:0] mode;
  } capture_ctrl_type;
endpackage

// ==== tb/pwm_duty_period_generator_monitor.sv ====
// port checker for the pwm block
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_period_generator_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic port_data_latch,
  input wire logic pwm_output_pin,
  input wire logic pwm_owns_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_ctrl;
    psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h00C;
  endsequence
  // answer and refusal
  property p_ans; s_setup |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_qual; pready |-> psel && penable; endproperty
  a_qual: assert property (p_qual) else $error("answer outside access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without answer");
  property p_unmap;
    s_setup ##0 (paddr == 12'h01C && !pwrite) |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read accepted");
  property p_mapped;
    s_setup ##0 (paddr <= 12'h018 && paddr[1:0] == 2'h0) |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  // pin ownership
  property p_mode0; s_wr_ctrl ##0 (pwdata[3:0] == 4'h0) |-> ##[1:2] !pwm_owns_pin; endproperty
  a_mode0: assert property (p_mode0) else $error("pin not released");
  property p_modec; s_wr_ctrl ##0 (pwdata[3:0] == 4'hC) |-> ##[1:2] pwm_owns_pin; endproperty
  a_modec: assert property (p_modec) else $error("pin not taken");
  property p_port;
    !pwm_owns_pin [*3] |-> pwm_output_pin == $past(port_data_latch);
  endproperty
  a_port: assert property (p_port) else $error("pin not following port");
endmodule // pwm_duty_period_generator_monitor
bind pwm_duty_period_generator pwm_duty_period_generator_monitor mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_data_latch(port_data_latch),
  .pwm_output_pin(pwm_output_pin), .pwm_owns_pin(pwm_owns_pin));
`default_nettype wire

// ==== tb/pwm_duty_period_generator_tb_top.sv ====
// self-checking bench of the pwm block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module pwm_duty_period_generator_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic port_data_latch = 1'b0, pready, pslverr, pin, owns, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  int n_mismatch = 0, compares = 0, hi, per, rises;
  always #10 pclk = ~pclk;
  pwm_duty_period_generator dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_data_latch(port_data_latch),
    .pwm_output_pin(pin), .pwm_owns_pin(owns));
  pwm_load_model load (.pclk(pclk), .pin(pin), .hi(hi), .per(per), .rises(rises));
  // one apb transfer, held until pready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
  task rdc(input logic [11:0] a, input logic [31:0] e); xfer(1'b0, a, 32'h0); `CHK(rd, e) endtask
  // wait for n new rising edges, bounded
  task rw(input int n);
    int t;
    t = rises + n;
    for (int k = 0; k < 3000 && rises < t; k++) @(posedge pclk);
    `CHK((rises >= t), 1'b1)
  endtask
  task steady(input logic v); repeat (20) begin @(negedge pclk); `CHK(pin, v) end endtask
  task complete_run;
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial begin #300000; n_mismatch++; complete_run; end
  // main sequence
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'hFF);
    rdc(12'h00C, 32'h0);
    xfer(1'b0, 12'h01C, 32'h0); `CHK(er, 1'b1)
    port_data_latch <= 1'b1;
    repeat (3) @(posedge pclk); `CHK(pin, 1'b1)
    wr(12'h000, 32'h3); wr(12'h004, 32'h4); wr(12'h008, 32'h2); wr(12'h00C, 32'h1C);
    rw(3); `CHK(hi, 9)
    `CHK(per, 16)
    wr(12'h004, 32'h5);
    rw(3); `CHK(hi, 36)
    `CHK(per, 64)
    wr(12'h010, 32'h3FF); rdc(12'h010, 32'h9);
    rw(1); wr(12'h008, 32'h1); rdc(12'h010, 32'h9);
    rw(1); rdc(12'h010, 32'h5);
    rw(1); `CHK(hi, 20)
    wr(12'h008, 32'h0); wr(12'h00C, 32'h0C);
    repeat (140) @(posedge pclk); steady(1'b0);
    wr(12'h008, 32'hFF);
    repeat (140) @(posedge pclk); steady(1'b1);
    wr(12'h00C, 32'h0); port_data_latch <= 1'b0;
    repeat (3) @(posedge pclk); `CHK(pin, 1'b0)
    `CHK(owns, 1'b0)
    complete_run;
  end
endmodule // pwm_duty_period_generator_tb_top
`default_nettype wire

// ==== tb/pwm_load_model.sv ====
// load on the pwm pin that measures high time and period
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model
(
  input wire logic pclk,
  input wire logic pin,
  output int hi,
  output int per,
  output int rises
);
  int h = 0, c = 0;
  logic last = 1'b0;
  initial {hi, per, rises} = '0;
  always @(posedge pclk)
  begin
    h <= h + (pin ? 1 : 0);
    c <= c + 1;
    if (pin && !last)
    begin
      hi <= h;
      per <= c;
      h <= 1;
      c <= 1;
      rises <= rises + 1;
    end
    last <= pin;
  end
endmodule // pwm_load_model
`default_nettype wire
